/* rtl/eme_top.sv */
`include "eme_regs.svh"

module eme_top import eme_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire logic [63:0] ds_base_i,
  output logic lk_req_o,
  output logic lk_sel_o,
  output logic [63:0] lk_addr_o,
  input wire logic lk_ack_i,
  input wire logic lk_in_cache_i,
  input wire logic lk_valid_i,
  input wire logic lk_busy_i,
  input wire logic [2:0] lk_type_i,
  input wire logic [63:0] lk_owner_i,
  input wire logic [63:0] lk_encl_addr_i,
  input wire logic lk_init_i,
  input wire logic lk_locked_i,
  input wire logic [63:0] lk_base_i,
  input wire logic [255:0] lk_meas_i,
  input wire logic [63:0] lk_cnt_i,
  output logic dat_req_o,
  output logic [63:0] dat_addr_o,
  input wire logic dat_ack_i,
  input wire logic [511:0] dat_i,
  output logic wb_o,
  output logic [255:0] wb_meas_o,
  output logic [63:0] wb_cnt_o,
  output logic ctl_hold_o
);

  // ---------------------------------------------------------------
  // Round constants
  // ---------------------------------------------------------------
  localparam logic [0:63][31:0] KTAB = {
    32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5,
    32'h3956C25B, 32'h59F111F1, 32'h923F82A4, 32'hAB1C5ED5,
    32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3,
    32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174,
    32'hE49B69C1, 32'hEFBE4786, 32'h0FC19DC6, 32'h240CA1CC,
    32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
    32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7,
    32'hC6E00BF3, 32'hD5A79147, 32'h06CA6351, 32'h14292967,
    32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13,
    32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85,
    32'hA2BFE8A1, 32'hA81A664B, 32'hC24B8B70, 32'hC76C51A3,
    32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
    32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5,
    32'h391C0CB3, 32'h4ED8AA4A, 32'h5B9CCA4F, 32'h682E6FF3,
    32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
    32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2
  };

  function automatic logic [31:0] rotr(input logic [31:0] x, input int n);
    return (x >> n) | (x << (32 - n));
  endfunction

  function automatic eme_kind_t kind_of(input eme_cause_t c);
    unique case (c)
      FC_NONE: return FK_NONE;
      FC_CP_RES, FC_DP_RES, FC_DP_INVALID, FC_DP_TYPE: return FK_PF;
      default: return FK_GP;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  eme_state_t state_q, state_d;
  eme_cause_t cause_d, cause_q;
  eme_kind_t kind_q;
  logic done_q;
  logic [1:0] priv_q;
  logic [63:0] cpop_q, dpop_q, cp_lin_q, dp_lin_q, cp_base_q, cnt_q;
  logic [2:0] cp_type_q;
  logic cp_busy_q, cp_init_q, cp_locked_q;
  logic [7:0][31:0] hv_q, wv_q;
  logic [15:0][31:0] w_q;
  logic [5:0] rnd_q;
  logic [2:0] blk_q;
  logic [1:0] int_stat_q, int_mask_q;
  logic [31:0] rdata_q;
  logic irq_q, lk_req_q, lk_sel_q, dat_req_q, wb_q, hold_q;
  logic [63:0] lk_addr_q, dat_addr_q, wb_cnt_q;
  logic [255:0] wb_meas_q;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_ctrl = we_i && (addr_i == `EME_OFS_CTRL);
  wire wr_priv = we_i && (addr_i == `EME_OFS_PRIV);
  wire wr_cplo = we_i && (addr_i == `EME_OFS_CPOP_LO);
  wire wr_cphi = we_i && (addr_i == `EME_OFS_CPOP_HI);
  wire wr_dplo = we_i && (addr_i == `EME_OFS_DPOP_LO);
  wire wr_dphi = we_i && (addr_i == `EME_OFS_DPOP_HI);
  wire wr_istat = we_i && (addr_i == `EME_OFS_INT_STAT);
  wire wr_imask = we_i && (addr_i == `EME_OFS_INT_MASK);
  wire idle = (state_q == ST_IDLE);
  // Start is ignored while busy; operands are frozen then too
  wire start = wr_ctrl && wdata_i[`EME_CTRL_START] && idle;
  wire [7:0] leaf_in = wdata_i[`EME_CTRL_LEAF_HI:`EME_CTRL_LEAF_LO];
  wire [31:0] status_w = {24'h000000, cause_q, kind_q, done_q, !idle};

  wire [31:0] rd_mux =
    (addr_i == `EME_OFS_PRIV) ? {30'h00000000, priv_q} :
    (addr_i == `EME_OFS_CPOP_LO) ? cpop_q[31:0] :
    (addr_i == `EME_OFS_CPOP_HI) ? cpop_q[63:32] :
    (addr_i == `EME_OFS_DPOP_LO) ? dpop_q[31:0] :
    (addr_i == `EME_OFS_DPOP_HI) ? dpop_q[63:32] :
    (addr_i == `EME_OFS_STATUS) ? status_w :
    (addr_i == `EME_OFS_INT_STAT) ? {30'h00000000, int_stat_q} :
    (addr_i == `EME_OFS_INT_MASK) ? {30'h00000000, int_mask_q} : 32'h00000000;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Data segment only
  wire [63:0] cp_lin = ds_base_i + cpop_q;
  wire [63:0] dp_lin = ds_base_i + dpop_q;
  wire cp_misal = (cp_lin_q & `EME_PAGE_MASK) != 64'h0;
  wire dp_misal = (dp_lin_q & `EME_CHUNK_MASK) != 64'h0;
  wire dp_type_ok = (lk_type_i == PT_REGULAR) || (lk_type_i == PT_THREAD) ||
                    (lk_type_i == FIRST_SHADOW_STACK_TYPE_T) || (lk_type_i == PT_SS_LATER);
  wire [63:0] encl_offs = lk_encl_addr_i - cp_base_q + (dp_lin_q & `EME_PAGE_MASK);
  wire [511:0] hdr_blk = {{`EME_HDR_PAD_W{1'b0}}, encl_offs, `EME_HDR_TAG};
  wire [511:0] blk_src = (state_q == ST_DP_WAIT) ? hdr_blk : dat_i;
  wire [1:0] piece = 2'(blk_q - 3'h1);

  // Byte 0 of the block is the first message byte; words are big-endian
  logic [15:0][31:0] msg;
  for (genvar t = 0; t < 16; t++) begin : g_msg
    assign msg[t] = {blk_src[32*t +: 8], blk_src[32*t+8 +: 8],
                     blk_src[32*t+16 +: 8], blk_src[32*t+24 +: 8]};
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cause_d = FC_NONE;
    unique case (state_q)
      ST_IDLE: begin
        if (start && leaf_in != `EME_LEAF_EXTEND) begin
          cause_d = FC_LEAF;
        end else if (start) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (priv_q != 2'h0) begin
          cause_d = FC_PRIV;
        end else if (cp_misal) begin
          cause_d = FC_CP_ALIGN;
        end else begin
          state_d = ST_CP_WAIT;
        end
      end
      ST_CP_WAIT: begin
        if (lk_ack_i && !lk_in_cache_i) begin
          cause_d = FC_CP_RES;
        end else if (lk_ack_i && dp_misal) begin
          cause_d = FC_DP_ALIGN;
        end else if (lk_ack_i) begin
          state_d = ST_DP_WAIT;
        end
      end
      ST_DP_WAIT: begin
        if (lk_ack_i) begin
          if (!lk_in_cache_i) begin
            cause_d = FC_DP_RES;
          end else if (lk_busy_i) begin
            cause_d = FC_MAP_BUSY;
          end else if (!lk_valid_i) begin
            cause_d = FC_DP_INVALID;
          end else if (!dp_type_ok) begin
            cause_d = FC_DP_TYPE;
          end else if (lk_owner_i != cp_lin_q) begin
            cause_d = FC_OWNER;
          end else if (cp_type_q != PT_CONTROL) begin
            cause_d = FC_CP_TYPE;
          end else if (cp_busy_q) begin
            cause_d = FC_CP_BUSY;
          end else if (cp_locked_q || cp_init_q) begin
            cause_d = FC_CP_STATE;
          end else begin
            state_d = ST_ROUND;
          end
        end
      end
      ST_ROUND: begin
        if (rnd_q == `EME_LAST_ROUND) begin
          state_d = ST_ADD;
        end
      end
      ST_ADD: begin
        state_d = (blk_q == `EME_LAST_BLK) ? ST_WB : ST_FETCH;
      end
      ST_FETCH: begin
        state_d = ST_FWAIT;
      end
      ST_FWAIT: begin
        if (dat_ack_i) begin
          state_d = ST_ROUND;
        end
      end
      ST_WB: begin
        state_d = ST_IDLE;
      end
    endcase
    if (cause_d != FC_NONE) begin
      state_d = ST_IDLE;
    end
  end

  wire flt_ev = (cause_d != FC_NONE);
  wire done_ev = (state_q == ST_WB);
  wire [1:0] ev = {flt_ev, done_ev};
  // Set wins over a same-cycle write-one clear
  wire [1:0] int_stat_d = (int_stat_q & ~(wr_istat ? wdata_i[1:0] : 2'h0)) | ev;

  // ---------------------------------------------------------------
  // Compression round
  // ---------------------------------------------------------------
  wire [31:0] ra = wv_q[7];
  wire [31:0] re = wv_q[3];
  wire [31:0] big_s1 = rotr(re, 6) ^ rotr(re, 11) ^ rotr(re, 25);
  wire [31:0] ch = (re & wv_q[2]) ^ (~re & wv_q[1]);
  wire [31:0] t1 = wv_q[0] + big_s1 + ch + KTAB[rnd_q] + w_q[0];
  wire [31:0] big_s0 = rotr(ra, 2) ^ rotr(ra, 13) ^ rotr(ra, 22);
  wire [31:0] maj = (ra & wv_q[6]) ^ (ra & wv_q[5]) ^ (wv_q[6] & wv_q[5]);
  wire [31:0] sm0 = rotr(w_q[1], 7) ^ rotr(w_q[1], 18) ^ (w_q[1] >> 3);
  wire [31:0] sm1 = rotr(w_q[14], 17) ^ rotr(w_q[14], 19) ^ (w_q[14] >> 10);
  wire [31:0] w_new = sm1 + w_q[9] + sm0 + w_q[0];
  wire [7:0][31:0] wv_next = {t1 + big_s0 + maj, wv_q[7:5], wv_q[4] + t1, wv_q[3:1]};
  wire load_blk = (state_q == ST_DP_WAIT && state_d == ST_ROUND) ||
                  (state_q == ST_FWAIT && dat_ack_i);

  // One compression per update, no padding
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wv_q <= '0;
      w_q <= '0;
      rnd_q <= 6'h00;
    end else if (load_blk) begin
      wv_q <= hv_q;
      w_q <= msg;
      rnd_q <= 6'h00;
    end else if (state_q == ST_ROUND) begin
      wv_q <= wv_next;
      w_q <= {w_new, w_q[15:1]};
      rnd_q <= rnd_q + 6'h01;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_hv
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        hv_q[i] <= 32'h00000000;
      end else if (state_q == ST_CP_WAIT && lk_ack_i) begin
        hv_q[i] <= lk_meas_i[32*i +: 32];
      end else if (state_q == ST_ADD) begin
        hv_q[i] <= hv_q[i] + wv_q[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Block sequence and counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blk_q <= 3'h0;
      cnt_q <= 64'h0;
    end else if (state_q == ST_CP_WAIT && lk_ack_i) begin
      blk_q <= 3'h0;
      cnt_q <= lk_cnt_i;
    end else if (state_q == ST_ADD) begin
      blk_q <= blk_q + 3'h1;
      if (blk_q == 3'h0) begin
        cnt_q <= cnt_q + `EME_CNT_HDR_INC;
      end else if (blk_q == `EME_LAST_BLK) begin
        cnt_q <= cnt_q + `EME_CNT_DAT_INC;
      end
    end
  end

  // ---------------------------------------------------------------
  // Operand capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cp_lin_q <= 64'h0;
      dp_lin_q <= 64'h0;
    end else if (start) begin
      cp_lin_q <= cp_lin;
      dp_lin_q <= dp_lin;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cp_base_q <= 64'h0;
      cp_type_q <= 3'h0;
      cp_busy_q <= 1'b0;
      cp_init_q <= 1'b0;
      cp_locked_q <= 1'b0;
    end else if (state_q == ST_CP_WAIT && lk_ack_i) begin
      cp_base_q <= lk_base_i;
      cp_type_q <= lk_type_i;
      cp_busy_q <= lk_busy_i;
      cp_init_q <= lk_init_i;
      cp_locked_q <= lk_locked_i;
    end
  end

  // ---------------------------------------------------------------
  // Far-side requests
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lk_req_q <= 1'b0;
      lk_sel_q <= 1'b0;
      lk_addr_q <= 64'h0;
    end else begin
      lk_req_q <= (state_d == ST_CP_WAIT && state_q == ST_CHECK) ||
                  (state_d == ST_DP_WAIT && state_q == ST_CP_WAIT);
      // Select and address stand until the next request is launched
      if (state_q == ST_CHECK && state_d == ST_CP_WAIT) begin
        lk_sel_q <= 1'b1;
        lk_addr_q <= cp_lin_q;
      end else if (state_q == ST_CP_WAIT && state_d == ST_DP_WAIT) begin
        lk_sel_q <= 1'b0;
        lk_addr_q <= dp_lin_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dat_req_q <= 1'b0;
      dat_addr_q <= 64'h0;
    end else begin
      dat_req_q <= (state_q == ST_FETCH);
      if (state_q == ST_FETCH) begin
        dat_addr_q <= dp_lin_q + (64'(piece) << `EME_PIECE_SHIFT);
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_q <= 1'b0;
      wb_q <= 1'b0;
      wb_meas_q <= 256'h0;
      wb_cnt_q <= 64'h0;
    end else begin
      hold_q <= (state_d != ST_IDLE) && (state_d == ST_ROUND || hold_q);
      wb_q <= done_ev;
      if (done_ev) begin
        wb_meas_q <= hv_q;
        wb_cnt_q <= cnt_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cause_q <= FC_NONE;
      kind_q <= FK_NONE;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start) begin
        done_q <= 1'b0;
        cause_q <= FC_NONE;
        kind_q <= FK_NONE;
      end
      if (flt_ev) begin
        cause_q <= cause_d;
        kind_q <= kind_of(cause_d);
      end
      if (done_ev) begin
        done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      priv_q <= 2'h0;
      cpop_q <= 64'h0;
      dpop_q <= 64'h0;
    end else if (idle) begin
      if (wr_priv) priv_q <= wdata_i[1:0];
      if (wr_cplo) cpop_q[31:0] <= wdata_i;
      if (wr_cphi) cpop_q[63:32] <= wdata_i;
      if (wr_dplo) dpop_q[31:0] <= wdata_i;
      if (wr_dphi) dpop_q[63:32] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_stat_q <= 2'h0;
      int_mask_q <= 2'h0;
      irq_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      int_stat_q <= int_stat_d;
      if (wr_imask) int_mask_q <= wdata_i[1:0];
      irq_q <= |(int_stat_d & (wr_imask ? wdata_i[1:0] : int_mask_q));
      rdata_q <= re_i ? rd_mux : 32'h00000000;
    end
  end

  assign rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign lk_req_o = lk_req_q;
  assign lk_sel_o = lk_sel_q;
  assign lk_addr_o = lk_addr_q;
  assign dat_req_o = dat_req_q;
  assign dat_addr_o = dat_addr_q;
  assign wb_o = wb_q;
  assign wb_meas_o = wb_meas_q;
  assign wb_cnt_o = wb_cnt_q;
  assign ctl_hold_o = hold_q;

endmodule

/* rtl/eme_regs.svh */
// Contract
// - Leaf selector 06H runs the extend; each run measures 256 bytes.
// - Fault unless privilege level is 0 and enclave is uninitialized.
// - Measured string is tag, enclave offset, zero padding, then 256 data bytes.
// - Control-page operand not 4096-byte aligned gives general protection fault.
// - Data operand not 256-byte aligned gives general protection fault.
// - Data address outside the protected page cache gives page fault.
// - Page map entry of data page not valid gives page fault.
// - Data page type not regular, thread, or shadow-stack gives page fault.
// - Control page not owner of data page gives general protection fault.
// - Control-page operand not of control-page type faults.
// - Concurrent access to the needed page map entry gives general protection fault.
// - Concurrent measurement or init-state access faults; control page held exclusively.
// - Locked or already initialized control page faults.
// - Offset is recorded enclave address minus base, plus low twelve address bits.
// - First hash a 512-bit header: tag in 63:0, offset in 127:64, zeros.
// - Then four 64-byte updates over the chunk, lowest bits first.
// - Update counter grows by one after header, by four after data.
// - Linear addresses use the data segment base only, no override.
`ifndef EME_REGS_SVH
`define EME_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define EME_OFS_CTRL 8'h00
`define EME_OFS_PRIV 8'h04
`define EME_OFS_CPOP_LO 8'h08
`define EME_OFS_CPOP_HI 8'h0C
`define EME_OFS_DPOP_LO 8'h10
`define EME_OFS_DPOP_HI 8'h14
`define EME_OFS_STATUS 8'h18
`define EME_OFS_INT_STAT 8'h1C
`define EME_OFS_INT_MASK 8'h20

// ---------------------------------------------------------------
// Fields and constants
// ---------------------------------------------------------------
`define EME_CTRL_LEAF_LO 0
`define EME_CTRL_LEAF_HI 7
`define EME_CTRL_START 8
`define EME_LEAF_EXTEND 8'h06
`define EME_PAGE_MASK 64'h0000_0000_0000_0FFF
`define EME_CHUNK_MASK 64'h0000_0000_0000_00FF
`define EME_HDR_TAG 64'h0044_4E45_5458_4545
`define EME_HDR_PAD_W 384
`define EME_PIECE_SHIFT 6
`define EME_LAST_ROUND 6'h3F
`define EME_LAST_BLK 3'h4
`define EME_CNT_HDR_INC 64'h0000_0000_0000_0001
`define EME_CNT_DAT_INC 64'h0000_0000_0000_0004
`define EME_IRQ_DONE 0
`define EME_IRQ_FAULT 1

`endif

/* rtl/eme_pkg.sv */
package eme_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CHECK = 4'h1,
    ST_CP_WAIT = 4'h2,
    ST_DP_WAIT = 4'h3,
    ST_ROUND = 4'h4,
    ST_ADD = 4'h5,
    ST_FETCH = 4'h6,
    ST_FWAIT = 4'h7,
    ST_WB = 4'h8
  } eme_state_t;

  typedef enum logic [1:0] {
    FK_NONE = 2'h0,
    FK_GP = 2'h1,
    FK_PF = 2'h2
  } eme_kind_t;

  typedef enum logic [3:0] {
    FC_NONE = 4'h0,
    FC_LEAF = 4'h1,
    FC_PRIV = 4'h2,
    FC_CP_ALIGN = 4'h3,
    FC_CP_RES = 4'h4,
    FC_DP_ALIGN = 4'h5,
    FC_DP_RES = 4'h6,
    FC_MAP_BUSY = 4'h7,
    FC_DP_INVALID = 4'h8,
    FC_DP_TYPE = 4'h9,
    FC_OWNER = 4'hA,
    FC_CP_TYPE = 4'hB,
    FC_CP_BUSY = 4'hC,
    FC_CP_STATE = 4'hD
  } eme_cause_t;

  typedef enum logic [2:0] {
    PT_UNUSED = 3'h0,
    PT_REGULAR = 3'h1,
    PT_THREAD = 3'h2,
    FIRST_SHADOW_STACK_TYPE_T = 3'h3,
    PT_SS_LATER = 3'h4,
    PT_CONTROL = 3'h5
  } eme_ptype_t;

endpackage

/* sim/eme_asserts.sv */
module eme_asserts import eme_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic lk_req_o,
  input wire logic lk_sel_o,
  input wire logic [63:0] lk_addr_o,
  input wire logic lk_ack_i,
  input wire logic [63:0] lk_cnt_i,
  input wire logic dat_req_o,
  input wire logic [63:0] dat_addr_o,
  input wire logic wb_o,
  input wire logic [63:0] wb_cnt_o,
  input wire logic ctl_hold_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [63:0] cnt_q;
  logic [63:0] dlk_q;
  logic [2:0] npc_q;
  // Counter as seen at the control lookup, pieces counted from data lookup
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 64'h0;
      dlk_q <= 64'h0;
      npc_q <= 3'h0;
    end else begin
      if (lk_ack_i && lk_sel_o) cnt_q <= lk_cnt_i;
      if (lk_req_o && !lk_sel_o) dlk_q <= lk_addr_o;
      if (lk_req_o && !lk_sel_o) npc_q <= 3'h0;
      else if (dat_req_o) npc_q <= npc_q + 3'h1;
    end
  end
  sequence s_dp_req;
    lk_req_o && !lk_sel_o;
  endsequence
  sequence s_last_req;
    dat_req_o && npc_q == 3'h3;
  endsequence
  order_after_a: assert property (s_dp_req |-> $past(lk_ack_i) && $past(lk_sel_o))
    else $error("data lookup not after control ack");
  cp_align_a: assert property (lk_req_o && lk_sel_o |-> lk_addr_o[11:0] == 12'h000)
    else $error("unaligned control page looked up");
  dp_align_a: assert property (s_dp_req |-> lk_addr_o[7:0] == 8'h00)
    else $error("unaligned data chunk looked up");
  piece_addr_a: assert property (dat_req_o |-> dat_addr_o == dlk_q + {55'h0, npc_q, 6'h00})
    else $error("piece address out of order");
  wb_pieces_a: assert property (wb_o |-> npc_q == 3'h4)
    else $error("writeback without four pieces");
  cnt_step_a: assert property (wb_o |-> wb_cnt_o == cnt_q + 64'h5)
    else $error("update counter not advanced by five");
  hold_wb_a: assert property (wb_o |-> $past(ctl_hold_o))
    else $error("writeback without exclusive hold");
  dreq_hold_a: assert property (dat_req_o |-> ctl_hold_o)
    else $error("piece fetch without exclusive hold");
  wb_after_a: assert property (s_last_req |-> ##[1:300] wb_o)
    else $error("no writeback after last piece");
endmodule

bind eme_top eme_asserts u_asserts (
  .clk_i(clk_i), .nrst_i(nrst_i), .lk_req_o(lk_req_o), .lk_sel_o(lk_sel_o),
  .lk_addr_o(lk_addr_o), .lk_ack_i(lk_ack_i), .lk_cnt_i(lk_cnt_i), .dat_req_o(dat_req_o),
  .dat_addr_o(dat_addr_o), .wb_o(wb_o), .wb_cnt_o(wb_cnt_o), .ctl_hold_o(ctl_hold_o)
);

/* sim/tb_top.sv */
`include "eme_regs.svh"

module tb_top import eme_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, nrst_i, we_i, re_i, irq_o, lk_req_o, lk_sel_o, lk_ack_i, lk_in_cache_i;
  logic lk_valid_i, lk_busy_i, lk_init_i, lk_locked_i, dat_req_o, dat_ack_i, wb_o, ctl_hold_o;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [2:0] lk_type_i;
  logic [63:0] ds_base_i, lk_addr_o, lk_owner_i, lk_encl_addr_i, lk_base_i, lk_cnt_i;
  logic [63:0] dat_addr_o, wb_cnt_o, cp, dp, d_owner, cnt_v, wcnt;
  logic [255:0] lk_meas_i, wb_meas_o;
  logic [511:0] dat_i;
  logic [1:0] prv;
  logic c_res, c_busy, c_init, c_lock, d_res, d_valid, d_busy;
  eme_ptype_t c_type, d_type;
  int n_mismatch, checks_done, n_wb, npc, dly;

  eme_top uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .ds_base_i(ds_base_i),
    .lk_req_o(lk_req_o), .lk_sel_o(lk_sel_o), .lk_addr_o(lk_addr_o), .lk_ack_i(lk_ack_i),
    .lk_in_cache_i(lk_in_cache_i), .lk_valid_i(lk_valid_i), .lk_busy_i(lk_busy_i),
    .lk_type_i(lk_type_i), .lk_owner_i(lk_owner_i), .lk_encl_addr_i(lk_encl_addr_i),
    .lk_init_i(lk_init_i), .lk_locked_i(lk_locked_i), .lk_base_i(lk_base_i),
    .lk_meas_i(lk_meas_i), .lk_cnt_i(lk_cnt_i), .dat_req_o(dat_req_o),
    .dat_addr_o(dat_addr_o), .dat_ack_i(dat_ack_i), .dat_i(dat_i), .wb_o(wb_o),
    .wb_meas_o(wb_meas_o), .wb_cnt_o(wb_cnt_o), .ctl_hold_o(ctl_hold_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ------
  // Far side: page map lookups and piece fetches
  // ------
  always begin
    @(posedge clk_i);
    if (lk_req_o) begin
      cmp("lookup address", ds_base_i + (lk_sel_o ? cp : dp), lk_addr_o);
      repeat (dly) @(posedge clk_i);
      lk_ack_i <= 1'b1;
      lk_in_cache_i <= lk_sel_o ? c_res : d_res;
      lk_busy_i <= lk_sel_o ? c_busy : d_busy;
      lk_type_i <= lk_sel_o ? c_type : d_type;
      {lk_valid_i, lk_init_i, lk_locked_i} <= {d_valid, c_init, c_lock};
      {lk_owner_i, lk_cnt_i, lk_meas_i} <= {d_owner, cnt_v, {8{32'h0F1E_2D3C}}};
      {lk_encl_addr_i, lk_base_i} <= {64'h0000_0000_0050_2000, 64'h0000_0000_0050_0000};
      @(posedge clk_i);
      lk_ack_i <= 1'b0;
      // Released fields must not keep looking valid
      {lk_owner_i, lk_encl_addr_i} <= ~{lk_owner_i, lk_encl_addr_i};
      {lk_base_i, lk_cnt_i} <= ~{lk_base_i, lk_cnt_i};
      {lk_busy_i, lk_in_cache_i} <= ~{lk_busy_i, lk_in_cache_i};
    end
  end

  always begin
    @(posedge clk_i);
    if (dat_req_o) begin
      cmp("piece address", ds_base_i + dp + 64'(npc * 64), dat_addr_o);
      npc++;
      repeat (dly) @(posedge clk_i);
      dat_ack_i <= 1'b1;
      dat_i <= {8{dat_addr_o}};
      @(posedge clk_i);
      dat_ack_i <= 1'b0;
      dat_i <= ~dat_i;
    end
  end

  always @(posedge clk_i) begin
    if (wb_o) begin
      n_wb++;
      wcnt = wb_cnt_o;
    end
  end

  // ------
  // Bus and checking tasks
  // ------
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(posedge clk_i);
    v = rdata_o;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    rd(a, v);
    cmp(nm, e, v);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic set_good();
    cp = 64'h0000_0000_0001_0000;
    dp = 64'h0000_0000_0002_0300;
    prv = 2'h0;
    {c_res, c_busy, c_init, c_lock, d_res, d_valid, d_busy} = 7'h46;
    c_type = PT_CONTROL;
    d_type = PT_REGULAR;
    d_owner = ds_base_i + cp;
  endtask

  // Kind 3 leaves the fault kind unchecked
  task automatic run_op(input logic [7:0] lf, input logic [1:0] kd, input logic [3:0] cs);
    logic [31:0] st;
    int i;
    int w0;
    w0 = n_wb;
    npc = 0;
    wr(`EME_OFS_CPOP_LO, cp[31:0]);
    wr(`EME_OFS_CPOP_HI, cp[63:32]);
    wr(`EME_OFS_DPOP_LO, dp[31:0]);
    wr(`EME_OFS_DPOP_HI, dp[63:32]);
    wr(`EME_OFS_PRIV, {30'h0, prv});
    wr(`EME_OFS_CTRL, {23'h0, 1'b1, lf});
    // A start landing while busy must be dropped
    wr(`EME_OFS_CTRL, {23'h0, 1'b1, lf});
    for (i = 0; i < 1000; i++) begin
      rd(`EME_OFS_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    if (i == 1000) begin
      n_mismatch++;
      report_and_stop();
    end
    cmp("fault cause", 64'(cs), 64'(st[7:4]));
    if (kd != 2'h3) cmp("fault kind", 64'(kd), 64'(st[3:2]));
    if (cs == 4'h0) cmp("done flag", 64'h1, 64'(st[1]));
    cmp("writebacks", 64'((cs == 4'h0) ? w0 + 1 : w0), 64'(n_wb));
    rd_chk(`EME_OFS_INT_STAT, (cs == 4'h0) ? 32'h1 : 32'h2, "event status");
    cmp("irq raised", 64'h1, 64'(irq_o));
    wr(`EME_OFS_INT_STAT, 32'h3);
    @(posedge clk_i);
    cmp("irq cleared", 64'h0, 64'(irq_o));
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    rd_chk(`EME_OFS_STATUS, 32'h0, "status reset");
    rd_chk(`EME_OFS_INT_STAT, 32'h0, "event reset");
    rd_chk(`EME_OFS_INT_MASK, 32'h0, "mask reset");
    wr(8'h3C, 32'hFFFF_FFFF);
    rd_chk(8'h3C, 32'h0, "unmapped");
    wr(`EME_OFS_INT_MASK, 32'h3);
    rd_chk(`EME_OFS_INT_MASK, 32'h3, "mask");
  endtask

  task automatic t_ok();
    eme_ptype_t ty [4];
    ty = '{PT_REGULAR, PT_THREAD, FIRST_SHADOW_STACK_TYPE_T, PT_SS_LATER};
    for (int k = 0; k < 4; k++) begin
      set_good();
      d_type = ty[k];
      dly = k;
      dp = dp + 64'(k * 256);
      // Counter wraps on every run
      cnt_v = 64'hFFFF_FFFF_FFFF_FFFC + 64'(k);
      run_op(`EME_LEAF_EXTEND, 2'h0, 4'h0);
      cmp("update counter", cnt_v + 64'h5, wcnt);
      cmp("pieces", 64'h4, 64'(npc));
      cmp("state moved", 64'h1, 64'(wb_meas_o != {8{32'h0F1E_2D3C}}));
    end
  endtask

  task automatic t_faults();
    logic [7:0] lf;
    logic [1:0] kd;
    logic [3:0] cs;
    for (int c = 1; c <= 15; c++) begin
      set_good();
      lf = `EME_LEAF_EXTEND;
      dly = c % 3;
      case (c)
        1: lf = 8'h05;
        2: prv = 2'h3;
        3: cp = cp | 64'h8;
        4: c_res = 1'b0;
        5: dp = dp | 64'h10;
        6: d_res = 1'b0;
        7: d_busy = 1'b1;
        8: d_valid = 1'b0;
        9: d_type = PT_UNUSED;
        10: d_owner = d_owner + 64'h1000;
        11: c_type = PT_REGULAR;
        12: c_busy = 1'b1;
        13: c_lock = 1'b1;
        14: c_init = 1'b1;
        default: d_type = PT_CONTROL;
      endcase
      cs = (c <= 13) ? c[3:0] : ((c == 14) ? 4'hD : 4'h9);
      kd = (c inside {4, 6, 8, 9, 15}) ? 2'h2 : 2'h1;
      if (c == 2) kd = 2'h3;
      run_op(lf, kd, cs);
    end
  endtask

  initial begin
    {nrst_i, we_i, re_i, lk_ack_i, dat_ack_i, lk_valid_i, lk_init_i, lk_locked_i} = 8'h00;
    {lk_in_cache_i, lk_busy_i, lk_type_i, addr_i, wdata_i, dat_i, lk_meas_i} = '0;
    {lk_owner_i, lk_encl_addr_i, lk_base_i, lk_cnt_i} = '0;
    ds_base_i = 64'h0000_0000_4000_0000;
    cnt_v = 64'h0;
    set_good();
    repeat (5) @(posedge clk_i);
    cmp("reset outputs", 64'h0, {wb_o, lk_req_o, dat_req_o, ctl_hold_o, irq_o, rdata_o});
    nrst_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_ok();
    t_faults();
    report_and_stop();
  end
endmodule
